// ### src/hpmc_consts.svh
// Offsets, field positions, configuration width and reset values of the host port mode bank.
// Assumes inclusion by bare name from the design files.
`ifndef HPMC_CONSTS_SVH
`define HPMC_CONSTS_SVH
`define HPMC_OFS_CONFIG    32'h40000008
`define HPMC_OFS_PAGE_TOP  32'h4000000c
`define HPMC_OFS_PAGE_UMB  32'h40000010
`define HPMC_BIT_BYTE_ADDR 4
`define HPMC_BIT_FULLWORD  3
`define HPMC_BIT_SEP_BUS   2
`define HPMC_BIT_PAGED     1
`define HPMC_BIT_ENABLE    0
`define HPMC_CFG_W         5
`define HPMC_RST_CONFIG    5'h00
`define HPMC_RST_PAGE      8'h00
`endif

// ### src/hpmc_pkg.sv
// Types shared by the host port mode bank.
// Assumes nothing beyond a SystemVerilog compiler.
package hpmc_pkg;
  typedef enum logic [1:0] {
    HPMC_MUX_HALF,
    HPMC_MUX_FULL,
    HPMC_SEPARATE
  } hpmc_bus_mode_t;
endpackage

// ### src/hpmc_addr_compose.sv
// Forms the internal address of a host access from the host supplied address.
// Assumes page bytes and mode bits come from the configuration bank.
`timescale 1ns/1ns
module hpmc_addr_compose
  import hpmc_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire hpmc_bus_mode_t busMode,
  input  wire logic           hostAddrIsByte,
  input  wire logic           pagedAddressingEn,
  input  wire logic [7:0]     pageAddrTopByte,
  input  wire logic [7:0]     pageAddrUpperMidByte,
  input  wire logic [31:0]    hostAddressRegister,
  input  wire logic [15:0]    hostAddrIn,
  output logic      [31:0]    internalAddr_ff
);
  // Word addresses become byte addresses by two low zero bits
  function automatic logic [31:0] toByteAddr(input logic [31:0] a, input logic isByte);
    toByteAddr = isByte ? a : {a[29:0], 2'b00};
  endfunction

  logic [31:0] nxt_internalAddr;
  logic [31:0] fromReg;
  logic [31:0] fromPins;

  always_comb begin
    fromReg  = toByteAddr(hostAddressRegister, hostAddrIsByte);
    fromPins = toByteAddr({16'h0000, hostAddrIn}, hostAddrIsByte);
    if (busMode == HPMC_SEPARATE) begin
      nxt_internalAddr = {pageAddrTopByte, pageAddrUpperMidByte, fromPins[15:0]};
    end else if (pagedAddressingEn) begin
      nxt_internalAddr = {pageAddrTopByte, pageAddrUpperMidByte, fromReg[15:0]};
    end else begin
      nxt_internalAddr = fromReg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      internalAddr_ff <= 32'h00000000;
    end else begin
      internalAddr_ff <= nxt_internalAddr;
    end
  end
endmodule

// ### src/hpmc_mode_bank.sv
// Host port mode bank: three registers on an AHB-Lite slave plus the mode outputs.
// Assumes one bus master, whole word single transfers, clk at 100 MHz.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "hpmc_consts.svh"
module hpmc_mode_bank
  import hpmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata_ff,
  input  wire logic        hostDataStrobe,
  input  wire logic [15:0] hostAddrIn,
  input  wire logic [31:0] hostAddressRegister,
  input  wire logic        internalAccessDone,
  input  wire logic        memIfaceUpperDataDriveReq,
  output logic             memIfaceUpperDataOe_n,
  output logic             hostReadyOut,
  output logic             hostAccessReq_ff,
  output logic      [31:0] internalAddr_ff,
  output logic             hostAddrIsByte,
  output logic             hostDataWide,
  output logic             separateAddrBusEn,
  output logic             pagedAddressingEn,
  output logic             portEnable
);
  logic [`HPMC_CFG_W-1:0] config_ff;
  logic [7:0]             pageTop_ff;
  logic [7:0]             pageUmb_ff;
  logic                   wrPend_ff;
  logic [31:0]            wrAddr_ff;
  logic                   addrPhase;
  logic [31:0]            rdValue;
  hpmc_bus_mode_t         busMode;

  function automatic logic isReg(input logic [31:0] a, input logic [31:0] ofs);
    isReg = (a == ofs);
  endfunction

  // Zero wait state slave, response always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && hready && htrans[1];

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 32'h00000000;
    end else begin
      wrPend_ff <= addrPhase && hwrite;
      wrAddr_ff <= haddr;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      config_ff <= `HPMC_RST_CONFIG;
    end else if (wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_CONFIG)) begin
      config_ff <= hwdata[`HPMC_CFG_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pageTop_ff <= `HPMC_RST_PAGE;
    end else if (wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_PAGE_TOP)) begin
      pageTop_ff <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pageUmb_ff <= `HPMC_RST_PAGE;
    end else if (wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_PAGE_UMB)) begin
      pageUmb_ff <= hwdata[7:0];
    end
  end

  always_comb begin
    rdValue = 32'h00000000;
    if (isReg(haddr, `HPMC_OFS_CONFIG)) begin
      rdValue[`HPMC_CFG_W-1:0] = config_ff;
    end else if (isReg(haddr, `HPMC_OFS_PAGE_TOP)) begin
      rdValue[7:0] = pageTop_ff;
    end else if (isReg(haddr, `HPMC_OFS_PAGE_UMB)) begin
      rdValue[7:0] = pageUmb_ff;
    end
  end

  // Read data sampled at the address phase; a write in the same edge is not yet visible
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_ff <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata_ff <= rdValue;
    end
  end

  assign hostAddrIsByte    = config_ff[`HPMC_BIT_BYTE_ADDR];
  assign separateAddrBusEn = config_ff[`HPMC_BIT_SEP_BUS];
  assign portEnable        = config_ff[`HPMC_BIT_ENABLE];
  assign pagedAddressingEn = config_ff[`HPMC_BIT_PAGED] && !separateAddrBusEn;

  always_comb begin
    case ({separateAddrBusEn, config_ff[`HPMC_BIT_FULLWORD]})
      2'b00:   busMode = HPMC_MUX_HALF;
      2'b01:   busMode = HPMC_MUX_FULL;
      default: busMode = HPMC_SEPARATE;
    endcase
  end
  assign hostDataWide = (busMode != HPMC_MUX_HALF);

  assign memIfaceUpperDataOe_n = !(memIfaceUpperDataDriveReq && !separateAddrBusEn);

  always_ff @(posedge clk) begin
    if (srst) begin
      hostAccessReq_ff <= 1'b0;
    end else begin
      hostAccessReq_ff <= hostDataStrobe && portEnable;
    end
  end

  assign hostReadyOut = portEnable && internalAccessDone;

  hpmc_addr_compose u_compose (
    .clk                  (clk),
    .srst                 (srst),
    .busMode              (busMode),
    .hostAddrIsByte       (hostAddrIsByte),
    .pagedAddressingEn    (pagedAddressingEn),
    .pageAddrTopByte      (pageTop_ff),
    .pageAddrUpperMidByte (pageUmb_ff),
    .hostAddressRegister  (hostAddressRegister),
    .hostAddrIn           (hostAddrIn),
    .internalAddr_ff      (internalAddr_ff)
  );

  a_cfg_write_lands: assert property (@(posedge clk) disable iff (srst)
    wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_CONFIG)
    |=> portEnable == $past(hwdata[`HPMC_BIT_ENABLE]))
    else $error("Enable bit did not take the written value");

  a_byte_addr_bit: assert property (@(posedge clk) disable iff (srst)
    wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_CONFIG)
    |=> hostAddrIsByte == $past(hwdata[`HPMC_BIT_BYTE_ADDR]))
    else $error("Address type bit did not take the written value");

  a_width_muxed: assert property (@(posedge clk) disable iff (srst)
    !separateAddrBusEn |-> hostDataWide == config_ff[`HPMC_BIT_FULLWORD])
    else $error("Data width does not follow the fullword bit");

  a_width_ignored: assert property (@(posedge clk) disable iff (srst)
    separateAddrBusEn |-> hostDataWide && busMode == HPMC_SEPARATE)
    else $error("Width bit acted in separate bus mode");

  a_sep_bus_bit: assert property (@(posedge clk) disable iff (srst)
    wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_CONFIG) && hwdata[`HPMC_BIT_SEP_BUS]
    |=> separateAddrBusEn && hostDataWide)
    else $error("Separate bus mode not entered after write");

  a_mem_no_drive: assert property (@(posedge clk) disable iff (srst)
    separateAddrBusEn |-> memIfaceUpperDataOe_n)
    else $error("Memory interface drives shared pins in separate bus mode");

  a_mem_drive_ok: assert property (@(posedge clk) disable iff (srst)
    !separateAddrBusEn && memIfaceUpperDataDriveReq |-> !memIfaceUpperDataOe_n)
    else $error("Memory interface blocked while multiplexed");

  a_page_top: assert property (@(posedge clk) disable iff (srst)
    separateAddrBusEn && $stable(pageTop_ff)
    |=> internalAddr_ff[31:24] == $past(pageTop_ff))
    else $error("Top page byte not on address bits 31 to 24");

  a_page_umb: assert property (@(posedge clk) disable iff (srst)
    pagedAddressingEn && $stable(pageUmb_ff)
    |=> internalAddr_ff[23:16] == $past(pageUmb_ff))
    else $error("Upper middle page byte not on address bits 23 to 16");

  a_full_address: assert property (@(posedge clk) disable iff (srst)
    !separateAddrBusEn && !pagedAddressingEn && hostAddrIsByte
    |=> internalAddr_ff == $past(hostAddressRegister))
    else $error("Full host address not passed through");

  a_reset_clear: assert property (@(posedge clk)
    srst |=> config_ff == `HPMC_RST_CONFIG && pageTop_ff == `HPMC_RST_PAGE
    && pageUmb_ff == `HPMC_RST_PAGE)
    else $error("Bank not cleared by reset");

  a_strobe_ignored: assert property (@(posedge clk) disable iff (srst)
    !portEnable |=> !hostAccessReq_ff)
    else $error("Host access made while port disabled");

  a_ready_gated: assert property (@(posedge clk) disable iff (srst)
    hostReadyOut |-> portEnable && internalAccessDone)
    else $error("Ready given while disabled or not done");

  a_read_data: assert property (@(posedge clk) disable iff (srst)
    addrPhase && !hwrite && isReg(haddr, `HPMC_OFS_PAGE_TOP)
    |=> hrdata_ff == {24'h000000, $past(pageTop_ff)})
    else $error("Page top byte read back wrong");

  a_cfg_word_lands: assert property (@(posedge clk) disable iff (srst)
    wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_CONFIG)
    |=> config_ff == $past(hwdata[`HPMC_CFG_W-1:0]))
    else $error("Configuration bits did not take the written word");

  a_cfg_holds: assert property (@(posedge clk) disable iff (srst)
    !(wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_CONFIG)) |=> $stable(config_ff))
    else $error("Configuration changed without a write");

  a_top_write_lands: assert property (@(posedge clk) disable iff (srst)
    wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_PAGE_TOP)
    |=> pageTop_ff == $past(hwdata[7:0]))
    else $error("Top page byte did not take the written value");

  a_top_holds: assert property (@(posedge clk) disable iff (srst)
    !(wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_PAGE_TOP)) |=> $stable(pageTop_ff))
    else $error("Top page byte changed without a write");

  a_umb_write_lands: assert property (@(posedge clk) disable iff (srst)
    wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_PAGE_UMB)
    |=> pageUmb_ff == $past(hwdata[7:0]))
    else $error("Upper middle page byte did not take the written value");

  a_umb_holds: assert property (@(posedge clk) disable iff (srst)
    !(wrPend_ff && isReg(wrAddr_ff, `HPMC_OFS_PAGE_UMB)) |=> $stable(pageUmb_ff))
    else $error("Upper middle page byte changed without a write");

  a_read_config: assert property (@(posedge clk) disable iff (srst)
    addrPhase && !hwrite && isReg(haddr, `HPMC_OFS_CONFIG)
    |=> hrdata_ff == {27'h0, $past(config_ff)})
    else $error("Configuration read back wrong");

  a_read_umb: assert property (@(posedge clk) disable iff (srst)
    addrPhase && !hwrite && isReg(haddr, `HPMC_OFS_PAGE_UMB)
    |=> hrdata_ff == {24'h000000, $past(pageUmb_ff)})
    else $error("Upper middle page byte read back wrong");

  a_read_unmapped: assert property (@(posedge clk) disable iff (srst)
    addrPhase && !hwrite && !isReg(haddr, `HPMC_OFS_CONFIG) && !isReg(haddr, `HPMC_OFS_PAGE_TOP)
    && !isReg(haddr, `HPMC_OFS_PAGE_UMB)
    |=> hrdata_ff == 32'h00000000)
    else $error("Unmapped address did not read zero");

  a_rdata_holds: assert property (@(posedge clk) disable iff (srst)
    !(addrPhase && !hwrite) |=> $stable(hrdata_ff))
    else $error("Read data changed without a read");

  a_paged_top: assert property (@(posedge clk) disable iff (srst)
    pagedAddressingEn |=> internalAddr_ff[31:24] == $past(pageTop_ff))
    else $error("Top page byte missing in paged mode");

  a_sep_umb: assert property (@(posedge clk) disable iff (srst)
    separateAddrBusEn |=> internalAddr_ff[23:16] == $past(pageUmb_ff))
    else $error("Upper middle page byte missing in separate bus mode");

  a_paged_mux_only: assert property (@(posedge clk) disable iff (srst)
    pagedAddressingEn |-> !separateAddrBusEn && config_ff[`HPMC_BIT_PAGED])
    else $error("Paging active outside multiplexed page mode");

  a_paged_low_half: assert property (@(posedge clk) disable iff (srst)
    pagedAddressingEn |=> internalAddr_ff[15:0] == ($past(hostAddrIsByte) ? $past(hostAddressRegister[15:0])
    : {$past(hostAddressRegister[13:0]), 2'b00}))
    else $error("Low address half wrong in paged mode");

  a_sep_low_half: assert property (@(posedge clk) disable iff (srst)
    separateAddrBusEn |=> internalAddr_ff[15:0] == ($past(hostAddrIsByte) ? $past(hostAddrIn)
    : {$past(hostAddrIn[13:0]), 2'b00}))
    else $error("Host address pins not on the low address half");

  a_word_full_address: assert property (@(posedge clk) disable iff (srst)
    !separateAddrBusEn && !pagedAddressingEn && !hostAddrIsByte
    |=> internalAddr_ff == {$past(hostAddressRegister[29:0]), 2'b00})
    else $error("Word address not turned into a byte address");

  a_half_width: assert property (@(posedge clk) disable iff (srst)
    !separateAddrBusEn && !config_ff[`HPMC_BIT_FULLWORD] |-> busMode == HPMC_MUX_HALF && !hostDataWide)
    else $error("Half-word mode not selected");

  a_mem_no_req: assert property (@(posedge clk) disable iff (srst)
    !memIfaceUpperDataDriveReq |-> memIfaceUpperDataOe_n)
    else $error("Memory interface drives shared pins unasked");

  a_access_req: assert property (@(posedge clk) disable iff (srst)
    portEnable && hostDataStrobe |=> hostAccessReq_ff)
    else $error("Enabled port dropped a host strobe");

  a_no_strobe_no_req: assert property (@(posedge clk) disable iff (srst)
    !hostDataStrobe |=> !hostAccessReq_ff)
    else $error("Host access made without a strobe");

  a_ready_follows: assert property (@(posedge clk) disable iff (srst)
    portEnable && internalAccessDone |-> hostReadyOut)
    else $error("Ready withheld after a finished access");

  a_ready_disabled: assert property (@(posedge clk) disable iff (srst)
    !portEnable |-> !hostReadyOut)
    else $error("Ready given while the port is disabled");

  a_reset_modes: assert property (@(posedge clk)
    srst |=> !portEnable && !separateAddrBusEn && !pagedAddressingEn && !hostAddrIsByte && !hostDataWide)
    else $error("Mode outputs not cleared by reset");

  a_reset_regs: assert property (@(posedge clk)
    srst |=> hrdata_ff == 32'h00000000 && !hostAccessReq_ff && internalAddr_ff == 32'h00000000)
    else $error("Output registers not cleared by reset");
endmodule

// ### bench/hpmc_host_model.sv
// Behavioural external host driving the host side of the mode bank.
// Assumes the bench pulses go for one cycle per access, then waits three cycles.
`timescale 1ns/1ns
module hpmc_host_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        go,
  input  wire logic [15:0] lowAddr,
  input  wire logic [31:0] fullAddr,
  output logic             hostDataStrobe,
  output logic      [15:0] hostAddrIn,
  output logic      [31:0] hostAddressRegister,
  output logic             internalAccessDone
);
  logic [1:0]  step_ff;
  logic [15:0] low_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      step_ff <= 2'h0;
    end else if (go || step_ff != 2'h0) begin
      step_ff <= step_ff + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      low_ff              <= 16'h0000;
      hostAddressRegister <= 32'h00000000;
    end else if (go) begin
      low_ff              <= lowAddr;
      hostAddressRegister <= fullAddr;
    end
  end
  assign hostDataStrobe     = (step_ff == 2'h2);
  assign internalAccessDone = (step_ff == 2'h3);
  // Released pins show the inverse, so a stale value cannot pass for a match
  assign hostAddrIn = (step_ff != 2'h0) ? low_ff : ~low_ff;
endmodule

// ### bench/hpmc_mode_bank_tb_top.sv
// Self-checking bench for the host port mode bank over AHB-Lite.
// Assumes the host model and the bank's zero-wait slave timing.
`timescale 1ns/1ns
module hpmc_mode_bank_tb_top;
  import hpmc_pkg::*;
  logic clk, srst, hsel, hwrite, hready, hreadyout, hresp, go, driveReq, oeN, strobe, done, req, rdy;
  logic [31:0] haddr, hwdata, hrdata, hostReg, iAddr, q;
  logic [1:0]  htrans;
  logic [15:0] hostLow;
  logic        isByte, wide, sep, paged, en;
  logic [4:0]  cfgs [6] = '{5'h01, 5'h11, 5'h09, 5'h13, 5'h15, 5'h17};
  int          num_errors = 0;
  int          n_checks = 0;
  assign hready = hreadyout;
  hpmc_mode_bank hpmc_mode_bank_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata_ff(hrdata), .hostDataStrobe(strobe), .hostAddrIn(hostLow), .hostAddressRegister(hostReg),
    .internalAccessDone(done), .memIfaceUpperDataDriveReq(driveReq), .memIfaceUpperDataOe_n(oeN),
    .hostReadyOut(rdy), .hostAccessReq_ff(req), .internalAddr_ff(iAddr), .hostAddrIsByte(isByte),
    .hostDataWide(wide), .separateAddrBusEn(sep), .pagedAddressingEn(paged), .portEnable(en));
  hpmc_host_model hpmc_host_model_inst (.clk(clk), .srst(srst), .go(go), .lowAddr(16'hbeef),
    .fullAddr(32'h12345678), .hostDataStrobe(strobe), .hostAddrIn(hostLow), .hostAddressRegister(hostReg),
    .internalAccessDone(done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic hold_ready;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) begin
      num_errors++;
      wrap_up;
    end
  endtask
  // One whole-word transfer; read data taken at the data phase's last edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hold_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold_ready();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Host access; sampled mid-cycle once the internal completion shows
  task automatic host(input logic on, input logic [31:0] expAddr);
    int i;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (done !== 1'b1 && i < 20);
    if (done !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    chk({30'h0, req, rdy}, {30'h0, on, on});
    if (on) chk(iAddr, expAddr);
  endtask
  function automatic logic [31:0] compose(input logic [4:0] c);
    if (c[2]) return {8'ha5, 8'h3c, 16'hbeef};
    if (c[1]) return {8'ha5, 8'h3c, 16'h5678};
    return c[4] ? 32'h12345678 : 32'h48d159e0;
  endfunction
  initial begin
    {hsel, hwrite, go, driveReq, htrans, haddr, hwdata} = '0;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(32'h40000008, 32'h0);
    rd(32'h4000000c, 32'h0);
    rd(32'h40000010, 32'h0);
    chk({31'h0, oeN}, 32'h00000001);
    driveReq <= 1'b1;
    host(1'b0, 32'h0);
    bus(1'b1, 32'h4000000c, 32'h000000a5);
    bus(1'b1, 32'h40000010, 32'h0000003c);
    bus(1'b1, 32'h40000014, 32'h000000ff);
    rd(32'h40000014, 32'h0);
    rd(32'h4000000c, 32'ha5);
    rd(32'h40000010, 32'h3c);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 32'h40000008, {27'h0, cfgs[k] & 5'h1e});
      host(1'b0, 32'h0);
      bus(1'b1, 32'h40000008, {27'h0, cfgs[k]});
      rd(32'h40000008, {27'h0, cfgs[k]});
      chk({27'h0, isByte, wide, sep, paged, en}, {27'h0, cfgs[k][4], cfgs[k][3] | cfgs[k][2], cfgs[k][2],
        cfgs[k][1] & ~cfgs[k][2], 1'b1});
      chk({31'h0, oeN}, {31'h0, cfgs[k][2]});
      host(1'b1, compose(cfgs[k]));
    end
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(32'h40000008, 32'h0);
    rd(32'h4000000c, 32'h0);
    wrap_up();
  end
endmodule
